// ### logic/swp_top.sv
// Purpose: Software standby release sequencer and register write protection.
// Assumes: Classic Wishbone slave, single clock, synchronous reset.
// Notes:   Pins pass a two-stage synchroniser before use.
//
// Chosen here: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Leave standby on NMI, pin IRQs, calendar, watchdog, monitor irqs or resets.
// - On interrupt wake restart only oscillators running before standby.
// - Wait programmed 5-bit stabilisation times before interrupt processing.
// - Reset pin low in standby starts oscillators and chip clock at once.
// - Power-on or voltage-monitor reset releases standby.
// - Watchdog underflow reset releases standby.
// - Watchdog reset cannot wake if watchdog stop held at standby entry.
// - I/O port states are held throughout standby.
// - A module in module stop runs no interrupt logic.
// - Timer interrupt wakes clock stop only if CPU clock is faster.
// - Protect bits 0, 1, 3 gate clock, power mode and voltage groups.
// - Protect bit 1 permits group writes, 0 forbids them.
// - Protect register updates only on 16-bit write with key upper byte; code also accepts any wider write that enables both low byte lanes.
// - Key byte never retains written data.
// - Reserved protect bits read zero; software writes zero.
module swp_top
  import swp_pkg::*;
#(
  parameter int WAIT_UNIT = UNIT_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        wait_instr_i,
  input  wire logic        external_reset_pin_n_i,
  input  wire logic        nmi_i,
  input  wire logic [7:0]  external_pin_interrupts_i,
  input  wire logic        rtc_alarm_i,
  input  wire logic        rtc_period_i,
  input  wire logic        wdt_irq_i,
  input  wire logic        vmon1_irq_i,
  input  wire logic        vmon2_irq_i,
  input  wire logic        por_i,
  input  wire logic        vmon_reset_i,
  input  wire logic        wdt_reset_i,
  input  wire logic        watchdog_start_select_i,
  input  wire logic        watchdog_autostart_lowpower_stop_i,
  input  wire logic        watchdog_regstart_lowpower_stop_i,
  input  wire logic        eight_bit_timer_irq_i,
  input  wire logic        cpu_clock_faster_i,
  output logic      [2:0]  osc_enable_o,
  output logic             clock_supply_o,
  output logic             io_hold_o,
  output logic             int_exception_o,
  output logic             reset_exception_o,
  output logic             timer_wake_o,
  output logic             rtc_irq_o
);
  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  generate
    if (WAIT_UNIT < 1 || WAIT_UNIT > 15) begin : g_bad_unit
      $error("WAIT_UNIT must be 1 to 15");
    end
  endgenerate
  function automatic logic [STAB_W-1:0] stab_cycles(input logic [4:0] f);
    return STAB_W'((f + 6'd1) * WAIT_UNIT);
  endfunction : stab_cycles
  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [9:0] pins_s;
  logic       pin_rst_n_s;
  logic       nmi_s;
  logic [7:0] irq_s;

  swp_sync #(
    .W       (10),
    .RST_VAL (10'h200)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({external_reset_pin_n_i, nmi_i, external_pin_interrupts_i}),
    .q_o   (pins_s)
  );
  assign pin_rst_n_s = pins_s[9];
  assign nmi_s       = pins_s[8];
  assign irq_s       = pins_s[7:0];
  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  logic        req;
  logic        wr;
  logic        key_ok;
  logic [3:0]  prot_reg;
  logic [2:0]  osc_en_reg;
  logic [2:0]  pwr_reg;
  logic [14:0] wait_reg;
  logic [1:0]  lvd_reg;
  logic [31:0] rd_next;
  logic        ack_reg;
  logic [31:0] dat_reg;
  assign req    = cyc_i & stb_i & ~ack_reg;
  assign wr     = req & we_i & sel_i[0];
  assign key_ok = (sel_i[1:0] == 2'b11) && (dat_i[15:8] == PROT_KEY);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prot_reg <= PROT_RST;
    end else if (wr && adr_i == PROT_ADDR && key_ok) begin
      prot_reg <= dat_i[3:0] & PROT_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_en_reg <= OSC_RST;
    end else if (wr && adr_i == CLK_ADDR && prot_reg[PRC_CLK]) begin
      osc_en_reg <= dat_i[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_reg  <= '0;
      wait_reg <= {WAIT_RST, WAIT_RST, WAIT_RST};
    end else if (wr && prot_reg[PRC_PWR]) begin
      if (adr_i == PWR_ADDR) begin
        pwr_reg <= dat_i[2:0];
      end
      if (adr_i == WAIT_ADDR) begin
        wait_reg <= {dat_i[FAST_POS+:5], dat_i[SUB_POS+:5], dat_i[MAIN_POS+:5]};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvd_reg <= '0;
    end else if (wr && adr_i == LVD_ADDR && prot_reg[PRC_LVD]) begin
      lvd_reg <= dat_i[1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Standby sequencer
  // ----------------------------------------------------------------------
  swp_state_type state_reg;
  swp_state_type state_next;
  logic [2:0]    snap_reg;
  logic          wdt_stop_reg;
  logic [1:0]    cause_reg;
  logic          wake_irq;
  logic          hard_reset;
  logic          stab_start;
  logic [2:0]    osc_done;
  logic          all_done;

  always_comb begin
    rd_next = '0;
    case (adr_i)
      PROT_ADDR: rd_next[3:0] = prot_reg & PROT_MASK;
      CLK_ADDR:  rd_next[2:0] = osc_en_reg;
      PWR_ADDR:  rd_next[2:0] = pwr_reg;
      WAIT_ADDR: begin
        rd_next[MAIN_POS+:5] = wait_reg[4:0];
        rd_next[SUB_POS+:5]  = wait_reg[9:5];
        rd_next[FAST_POS+:5] = wait_reg[14:10];
      end
      LVD_ADDR:  rd_next[1:0] = lvd_reg;
      STAT_ADDR: rd_next[9:0] = {cause_reg, wdt_stop_reg, snap_reg, state_reg};
      default:   rd_next = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
    end else begin
      ack_reg <= req;
      dat_reg <= req ? rd_next : dat_reg;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;

  assign rtc_irq_o  = (rtc_alarm_i | rtc_period_i) & ~pwr_reg[MSTP_RTC];
  assign wake_irq   = nmi_s | (|irq_s) | rtc_irq_o | wdt_irq_i
                    | (vmon1_irq_i & lvd_reg[0]) | (vmon2_irq_i & lvd_reg[1]);
  assign hard_reset = por_i | vmon_reset_i | (wdt_reset_i & ~wdt_stop_reg);
  assign stab_start = (state_reg == ST_SBY) && (state_next == ST_STAB);
  assign all_done   = &osc_done;
  assign timer_wake_o = eight_bit_timer_irq_i & ~pwr_reg[MSTP_TIMER]
                      & cpu_clock_faster_i;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (wait_instr_i && pwr_reg[SBY_BIT]) begin
          state_next = ST_SBY;
        end
      end
      ST_SBY: begin
        if (hard_reset) begin
          state_next = ST_RUN;
        end else if (!pin_rst_n_s) begin
          state_next = ST_RHOLD;
        end else if (wake_irq) begin
          state_next = ST_STAB;
        end
      end
      ST_STAB: begin
        if (hard_reset) begin
          state_next = ST_RUN;
        end else if (!pin_rst_n_s) begin
          state_next = ST_RHOLD;
        end else if (all_done) begin
          state_next = ST_RUN;
        end
      end
      ST_RHOLD: begin
        if (pin_rst_n_s) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_RUN;
    endcase
  end

  for (genvar i = 0; i < 3; i++) begin : g_osc
    swp_stab_timer #(
      .W (STAB_W)
    ) u_timer (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (stab_start),
      .load_i  (snap_reg[i] ? stab_cycles(wait_reg[5*i+:5]) : '0),
      .done_o  (osc_done[i])
    );
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      snap_reg     <= '0;
      wdt_stop_reg <= 1'b0;
    end else if (state_reg == ST_RUN && state_next == ST_SBY) begin
      snap_reg     <= osc_en_reg;
      wdt_stop_reg <= watchdog_start_select_i ? watchdog_regstart_lowpower_stop_i
                                              : watchdog_autostart_lowpower_stop_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cause_reg         <= CAUSE_NONE;
      int_exception_o   <= 1'b0;
      reset_exception_o <= 1'b0;
    end else begin
      int_exception_o   <= (state_reg == ST_STAB) && (state_next == ST_RUN) && !hard_reset;
      reset_exception_o <= (state_reg != ST_RUN) && (state_next == ST_RUN)
                           && (hard_reset || state_reg == ST_RHOLD);
      if (state_reg == ST_SBY && state_next != ST_SBY) begin
        cause_reg <= hard_reset ? CAUSE_INT : (!pin_rst_n_s ? CAUSE_PIN : CAUSE_IRQ);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_enable_o   <= OSC_RST;
      clock_supply_o <= 1'b1;
      io_hold_o      <= 1'b0;
    end else begin
      case (state_next)
        ST_SBY:   osc_enable_o <= '0;
        ST_STAB:  osc_enable_o <= snap_reg;
        ST_RHOLD: osc_enable_o <= '1;
        default:  osc_enable_o <= osc_en_reg;
      endcase
      clock_supply_o <= (state_next == ST_RUN) || (state_next == ST_RHOLD);
      io_hold_o      <= (state_next == ST_SBY) || (state_next == ST_STAB);
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb_sys @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_sby_irq;
    state_reg == ST_SBY && wake_irq && pin_rst_n_s && !hard_reset;
  endsequence
  sequence s_stab_ok;
    state_reg == ST_STAB && all_done && pin_rst_n_s && !hard_reset;
  endsequence
  property p_wake_irq;
    s_sby_irq |=> state_reg == ST_STAB;
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("irq did not wake");
  property p_osc_restart;
    s_sby_irq |=> osc_enable_o == snap_reg;
  endproperty
  a_osc_restart: assert property (p_osc_restart) else $error("wrong oscillators");
  property p_int_exc;
    s_stab_ok |=> int_exception_o && !io_hold_o;
  endproperty
  a_int_exc: assert property (p_int_exc) else $error("no interrupt processing");
  property p_int_cause;
    int_exception_o |-> $past(state_reg) == ST_STAB && $past(all_done);
  endproperty
  a_int_cause: assert property (p_int_cause) else $error("early exit");
  property p_pin_clock;
    state_reg == ST_SBY && !pin_rst_n_s && !hard_reset
    |=> clock_supply_o && osc_enable_o == 3'h7;
  endproperty
  a_pin_clock: assert property (p_pin_clock) else $error("clock not started");
  property p_wdt_blocked;
    state_reg == ST_SBY && wdt_stop_reg && !por_i && !vmon_reset_i
    && !wake_irq && pin_rst_n_s |=> state_reg == ST_SBY;
  endproperty
  a_wdt_blocked: assert property (p_wdt_blocked) else $error("watchdog woke");
  property p_io_hold;
    io_hold_o == (state_reg == ST_SBY || state_reg == ST_STAB);
  endproperty
  a_io_hold: assert property (p_io_hold) else $error("io hold wrong");
  property p_bad_key;
    wr && adr_i == PROT_ADDR && !key_ok |=> $stable(prot_reg);
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("protect changed");
  property p_locked;
    !prot_reg[PRC_CLK] |=> $stable(osc_en_reg);
  endproperty
  a_locked: assert property (p_locked) else $error("locked write took");
  property p_rsv_zero;
    req && adr_i == PROT_ADDR |=> dat_o[15:4] == 12'h000 && !dat_o[2];
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved set");
  property p_timer_wake;
    !cpu_clock_faster_i |-> !timer_wake_o;
  endproperty
  a_timer_wake: assert property (p_timer_wake) else $error("timer woke");
endmodule : swp_top
`default_nettype wire

// ### logic/swp_pkg.sv
// Purpose: Shared constants for the standby wake and write protect block.
// Assumes: 32-bit classic Wishbone register bus, 10 MHz system clock.
// Notes:   Byte addresses are word aligned.
package swp_pkg;
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [31:0] PROT_IDX   = 32'h000803fe;
  localparam logic [31:0] PROT_ADDR  = 32'h00200ff8;
  localparam logic [31:0] CLK_ADDR   = 32'h00201000;
  localparam logic [31:0] PWR_ADDR   = 32'h00201004;
  localparam logic [31:0] WAIT_ADDR  = 32'h00201008;
  localparam logic [31:0] LVD_ADDR   = 32'h0020100c;
  localparam logic [31:0] STAT_ADDR  = 32'h00201010;
  // ----------------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0]  PROT_KEY   = 8'ha5;
  localparam int          PRC_CLK    = 0;
  localparam int          PRC_PWR    = 1;
  localparam int          PRC_LVD    = 3;
  localparam logic [3:0]  PROT_MASK  = 4'hb;
  localparam logic [3:0]  PROT_RST   = 4'h0;
  localparam logic [2:0]  OSC_RST    = 3'h4;
  localparam int          MAIN_POS   = 0;
  localparam int          SUB_POS    = 8;
  localparam int          FAST_POS   = 16;
  localparam logic [4:0]  WAIT_RST   = 5'h1f;
  localparam int          SBY_BIT    = 0;
  localparam int          MSTP_TIMER = 1;
  localparam int          MSTP_RTC   = 2;
  localparam logic [1:0]  CAUSE_NONE = 2'h0;
  localparam logic [1:0]  CAUSE_IRQ  = 2'h1;
  localparam logic [1:0]  CAUSE_PIN  = 2'h2;
  localparam logic [1:0]  CAUSE_INT  = 2'h3;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int          CLK_NS     = 100;
  localparam int          UNIT_NS    = 1000;
  localparam int          UNIT_CYC   = (UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int          STAB_W     = 9;
  // ----------------------------------------------------------------------
  // Standby sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RUN   = 4'b0001,
    ST_SBY   = 4'b0010,
    ST_STAB  = 4'b0100,
    ST_RHOLD = 4'b1000
  } swp_state_type;
endpackage : swp_pkg

// ### logic/swp_sync.sv
// Purpose: Two flip-flop synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to clk_i.
// Notes:   The first stage feeds only the second.
`timescale 1ns/100ps
`default_nettype none
module swp_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= RST_VAL;
      q_reg    <= RST_VAL;
    end else begin
      meta_reg <= d_i;
      q_reg    <= meta_reg;
    end
  end

  assign q_o = q_reg;
endmodule : swp_sync
`default_nettype wire

// ### logic/swp_stab_timer.sv
// Purpose: Oscillator stabilisation down-counter.
// Assumes: start_i is a one-cycle pulse.
// Notes:   done_o is high whenever the count is zero.
`timescale 1ns/100ps
`default_nettype none
module swp_stab_timer #(
  parameter int W = 9
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         start_i,
  input  wire logic [W-1:0] load_i,
  output logic              done_o
);
  logic [W-1:0] cnt_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else if (start_i) begin
      cnt_reg <= load_i;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - W'(1);
    end
  end

  assign done_o = (cnt_reg == '0);
endmodule : swp_stab_timer
`default_nettype wire

// ### test/swp_top_tb.sv
// Purpose: Self-checking bench for the standby wake and write protect block.
// Assumes: Classic Wishbone master, 10 MHz clock, shortened wait unit.
// Notes:   Reads are checked by a monitor against a queue of expected data.
`timescale 1ns/100ps
`default_nettype none
module swp_top_tb;
  import swp_pkg::*;
  localparam int WU = 2;
  logic        clk, rst, cyc, stb, we, wi, pin_n, tirq, cfast, wsel, wauto, wreg;
  logic        ack, clk_sup, hold, iexc, rexc, twake, rtci;
  logic [31:0] adr, wdat, rdat;
  logic [3:0]  sel;
  logic [13:0] src;
  logic [2:0]  rsrc, osc;
  logic [31:0] rq[$];
  int          n_fail, n_checks;

  swp_top #(.WAIT_UNIT(WU)) u_dut (
    .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .wait_instr_i(wi),
    .external_reset_pin_n_i(pin_n), .nmi_i(src[8]), .external_pin_interrupts_i(src[7:0]),
    .rtc_alarm_i(src[9]), .rtc_period_i(src[10]), .wdt_irq_i(src[11]),
    .vmon1_irq_i(src[12]), .vmon2_irq_i(src[13]), .por_i(rsrc[0]),
    .vmon_reset_i(rsrc[1]), .wdt_reset_i(rsrc[2]), .watchdog_start_select_i(wsel),
    .watchdog_autostart_lowpower_stop_i(wauto), .watchdog_regstart_lowpower_stop_i(wreg),
    .eight_bit_timer_irq_i(tirq), .cpu_clock_faster_i(cfast), .osc_enable_o(osc),
    .clock_supply_o(clk_sup), .io_hold_o(hold), .int_exception_o(iexc),
    .reset_exception_o(rexc), .timer_wake_o(twake), .rtc_irq_o(rtci)
  );

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [31:0] e);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    if (!w) rq.push_back(e);
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    chk("bus ack one cycle", {31'h0, ack}, 32'h0);
  endtask : wb

  task automatic wait_exc(input logic rs, input int lim, output int n);
    n = 0;
    while ((rs ? rexc : iexc) !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_exc

  task automatic sby();
    wi <= 1'b1;
    @(posedge clk);
    wi <= 1'b0;
    repeat (2) @(posedge clk);
    chk("io hold", {31'h0, hold}, 32'h1);
  endtask : sby

  task automatic wake(input int i, input int lo, input int hi);
    int n;
    sby();
    src[i] <= 1'b1;
    wait_exc(1'b0, 200, n);
    src[i] <= 1'b0;
    chk("irq wake delay", {31'h0, n >= lo && n <= hi}, 32'h1);
    repeat (3) @(posedge clk);
  endtask : wake

  // ------------------------------------------------------------------
  // Read monitor, clock and watchdog
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && rq.size() > 0) begin
      chk("read data", rdat, rq.pop_front());
    end
  end

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    $display("CHECK FAILED run time expected finish seen timeout");
    final_report();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    int r, n;
    {rst, cyc, stb, we, wi, tirq, cfast, wsel, wauto, wreg} = 10'h200;
    {adr, wdat, sel, src, rsrc} = '0;
    pin_n = 1'b1;
    n_fail = 0;
    n_checks = 0;
    r = $urandom(90682);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    r = $urandom;
    wb(0, PROT_ADDR, 0, 4'h3, 32'h0);
    wb(0, WAIT_ADDR, 0, 4'hf, {11'h0, WAIT_RST, 3'h0, WAIT_RST, 3'h0, WAIT_RST});
    wb(1, CLK_ADDR, r, 4'hf, 0);
    wb(0, CLK_ADDR, 0, 4'hf, {29'h0, OSC_RST});
    wb(0, 32'h00300000, 0, 4'hf, 32'h0);
    $display("test done: reset values and locked writes");
    wb(1, PROT_ADDR, {16'h0, 8'h5a, 8'h0b}, 4'h3, 0);
    wb(0, PROT_ADDR, 0, 4'h3, 32'h0);
    wb(1, PROT_ADDR, {16'h0, PROT_KEY, 8'h0b}, 4'h1, 0);
    wb(0, PROT_ADDR, 0, 4'h3, 32'h0);
    wb(1, PROT_ADDR, {r[31:16], PROT_KEY, 8'h01}, 4'h3, 0);
    wb(0, PROT_ADDR, 0, 4'h3, 32'h1);
    wb(1, WAIT_ADDR, 32'h0, 4'hf, 0);
    wb(0, WAIT_ADDR, 0, 4'hf, {11'h0, WAIT_RST, 3'h0, WAIT_RST, 3'h0, WAIT_RST});
    wb(1, LVD_ADDR, 32'h3, 4'hf, 0);
    wb(0, LVD_ADDR, 0, 4'hf, 32'h0);
    wb(1, CLK_ADDR, 32'h3, 4'hf, 0);
    wb(0, CLK_ADDR, 0, 4'hf, 32'h3);
    wb(1, PROT_ADDR, {16'h0, PROT_KEY, 8'h0b}, 4'h3, 0);
    wb(1, WAIT_ADDR, 32'h001f0703, 4'hf, 0);
    wb(0, WAIT_ADDR, 0, 4'hf, 32'h001f0703);
    wb(1, LVD_ADDR, 32'h3, 4'hf, 0);
    wb(0, LVD_ADDR, 0, 4'hf, 32'h3);
    $display("test done: protect register and groups");
    wb(1, PWR_ADDR, 32'h1, 4'hf, 0);
    wb(0, PWR_ADDR, 0, 4'hf, 32'h1);
    for (int i = 0; i < 14; i++) begin
      wake(i, 8 * WU, 8 * WU + 8);
      chk("restarted oscillators", {29'h0, osc}, 32'h3);
    end
    $display("test done: interrupt wake sources");
    for (int i = 0; i < 3; i++) begin
      sby();
      rsrc[i] <= 1'b1;
      wait_exc(1'b1, 20, n);
      rsrc[i] <= 1'b0;
      chk("internal reset wake", {31'h0, n < 20}, 32'h1);
      repeat (3) @(posedge clk);
    end
    for (int k = 0; k < 3; k++) begin
      wsel  <= (k != 0);
      wauto <= (k != 2);
      wreg  <= (k == 2);
      @(posedge clk);
      sby();
      rsrc[2] <= 1'b1;
      wait_exc(1'b1, 20, n);
      rsrc[2] <= 1'b0;
      chk("watchdog wake", {31'h0, n < 20}, {31'h0, k == 1});
      if (k != 1) begin
        src[8] <= 1'b1;
        wait_exc(1'b0, 200, n);
        src[8] <= 1'b0;
      end
      repeat (3) @(posedge clk);
    end
    $display("test done: reset wake sources");
    sby();
    pin_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk("pin oscillators", {29'h0, osc}, 32'h7);
    chk("pin clock supply", {31'h0, clk_sup}, 32'h1);
    repeat (70) @(posedge clk);
    chk("no early reset start", {31'h0, rexc}, 32'h0);
    pin_n <= 1'b1;
    wait_exc(1'b1, 10, n);
    chk("pin release", {31'h0, n < 10}, 32'h1);
    repeat (3) @(posedge clk);
    wb(0, STAT_ADDR, 0, 4'hf, {22'h0, CAUSE_PIN, 1'b1, 3'h3, ST_RUN});
    $display("test done: reset pin wake");
    tirq   <= 1'b1;
    cfast  <= 1'b1;
    src[9] <= 1'b1;
    wb(1, PWR_ADDR, 32'h0, 4'hf, 0);
    chk("timer wake", {31'h0, twake}, 32'h1);
    chk("calendar irq", {31'h0, rtci}, 32'h1);
    cfast <= 1'b0;
    @(posedge clk);
    chk("timer wake slow cpu", {31'h0, twake}, 32'h0);
    cfast <= 1'b1;
    wb(1, PWR_ADDR, 32'h6, 4'hf, 0);
    chk("timer stopped", {31'h0, twake}, 32'h0);
    chk("calendar stopped", {31'h0, rtci}, 32'h0);
    $display("test done: module stop and timer wake");
    final_report();
  end
endmodule : swp_top_tb
`default_nettype wire
